// [board_watchdog_timer.sv]
// Board watchdog timer with control, routing and reset cause registers
`timescale 1ns/1ps
`include "wdt_regs.svh"

// Overview of operation
// - Four-bit period select, doubling from 0.125 s
// - Disarmed after power-on, nothing fires
// - Armed: disarm and mode change ignored
// - Retrigger write reloads selected period
// - Arm bit reads one while armed
// - Every timeout sets the expired flag
// - Writing one clears expired flag
// - Expired flag also cleared by power-on
// - Two-bit mode: timer, reset, irq, dual
// - Timer mode only sets the flag
// - Reset mode timeout forces hard reset
// - Interrupt mode raises irq, no reset
// - Dual first timeout: irq and auto reload
// - Dual second timeout unbroken: hard reset
// - Irq routing from separate routing register
// - Routing 00 off, 01 line five
// - Watchdog reset sets cause flag, W1C
module board_watchdog_timer #(
	parameter int unsigned TICK_CYCLES = `WDT_TICK_CYC // Clock cycles per 0.125 s tick
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [9:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	output logic irq_line5_out,
	output logic hard_reset_out
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int unsigned RST_PULSE = `WDT_RST_PULSE_CYC; // Hard reset width
	wdt_pkg::wdt_state_e state_ff; // Sequencer state
	wdt_pkg::mode_e mode_ff; // Selected behaviour
	wdt_pkg::ctrl_s ctrl_rd; // Control read image
	logic [3:0] period_ff; // Selected period code
	logic [1:0] route_ff; // Interrupt routing field
	logic [22:0] tick_cnt_ff; // Prescaler
	logic [15:0] cnt_ff; // Countdown in ticks
	logic [15:0] load_val; // Reload value from write data
	logic [15:0] period_val; // Reload value from held period
	logic [5:0] rst_cnt_ff; // Hard reset pulse counter
	logic expired_ff; // Sticky expired flag
	logic irq_pend_ff; // Interrupt pending
	logic cause_ff; // Watchdog reset cause
	logic irq_ff; // Routed interrupt
	logic rst_out_ff; // Hard reset drive
	logic [7:0] rd_data_ff; // Read data
	logic armed; // Watchdog armed
	logic wr_ctrl; // Control register write
	logic rd_ctrl; // Control register read
	logic arm_req; // Arm or retrigger
	logic tick; // Prescaler wrap
	logic timeout; // Countdown expiry
	logic fire_reset; // Watchdog asks for hard reset
	logic clr_expired; // Software clears expired flag

	// Ticks to load for a period code: two to the code, minus one
	function automatic logic [15:0] period_ticks(input logic [3:0] sel);
		period_ticks = (16'h1 << sel) - 16'h1;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign wr_ctrl = wr_en_in && (addr_in == `WDT_ADDR_CONTROL);
	assign rd_ctrl = rd_en_in && (addr_in == `WDT_ADDR_CONTROL);
	assign arm_req = wr_ctrl && wr_data_in[`WDT_ARM_BIT];
	assign clr_expired = wr_ctrl && wr_data_in[`WDT_EXPIRED_BIT];
	assign armed = (state_ff != wdt_pkg::ST_DISARMED);
	assign load_val = period_ticks(wr_data_in[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB]);
	assign period_val = period_ticks(period_ff);
	assign tick = (tick_cnt_ff == 23'(TICK_CYCLES - 1));
	// Expiry only while counting or in the grace stage
	assign timeout = tick && (cnt_ff == 16'h0)
		&& (state_ff == wdt_pkg::ST_COUNTING || state_ff == wdt_pkg::ST_GRACE);
	// Reset mode, or dual second stage with no retrigger between
	assign fire_reset = timeout && ((mode_ff == wdt_pkg::MODE_RESET)
		|| (mode_ff == wdt_pkg::MODE_DUAL && state_ff == wdt_pkg::ST_GRACE));

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Mode locks once armed; power-on reset is the only unlock
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mode_ff <= wdt_pkg::MODE_TIMER;
		end else if (wr_ctrl && !armed) begin
			mode_ff <= wdt_pkg::mode_e'(wr_data_in[`WDT_MODE_MSB:`WDT_MODE_LSB]);
		end
	end

	// Period code stays writable; it sets the next reload
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			period_ff <= `WDT_PERIOD_RST;
		end else if (wr_ctrl) begin
			period_ff <= wr_data_in[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];
		end
	end

	// Interrupt routing field in its own register
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			route_ff <= `WDT_ROUTE_RST;
		end else if (wr_en_in && addr_in == `WDT_ADDR_IRQ_ROUTING) begin
			route_ff <= wr_data_in[`WDT_ROUTE_MSB:`WDT_ROUTE_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Tick and countdown
	// ----------------------------------------------------------------
	// Prescaler restarts on every load so a period is exact
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || arm_req || tick) begin
			tick_cnt_ff <= 23'h0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 23'h1;
		end
	end

	// Countdown load, dual stage reload, decrement
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 16'h0;
		end else if (arm_req) begin
			cnt_ff <= load_val;
		end else if (timeout && mode_ff == wdt_pkg::MODE_DUAL && state_ff == wdt_pkg::ST_COUNTING) begin
			cnt_ff <= period_val;
		end else if (tick && cnt_ff != 16'h0) begin
			cnt_ff <= cnt_ff - 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Never returns to disarmed except by power-on reset
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_ff <= wdt_pkg::ST_DISARMED;
		end else begin
			unique case (state_ff)
				// Arming, or retrigger after a stopped timeout
				wdt_pkg::ST_DISARMED, wdt_pkg::ST_EXPIRED: begin
					if (arm_req) begin
						state_ff <= wdt_pkg::ST_COUNTING;
					end
				end
				// Retrigger keeps counting; dual mode enters grace
				wdt_pkg::ST_COUNTING: begin
					if (timeout && !arm_req) begin
						state_ff <= (mode_ff == wdt_pkg::MODE_DUAL) ? wdt_pkg::ST_GRACE : wdt_pkg::ST_EXPIRED;
					end
				end
				wdt_pkg::ST_GRACE: begin
					// Retrigger resumes normal counting
					if (arm_req) begin
						state_ff <= wdt_pkg::ST_COUNTING;
					end else if (timeout) begin
						state_ff <= wdt_pkg::ST_EXPIRED;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Expired flag: set wins over clear; power-on also resets it
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			expired_ff <= 1'b0;
		end else if (timeout) begin
			expired_ff <= 1'b1;
		end else if (clr_expired) begin
			expired_ff <= 1'b0;
		end
	end

	// Interrupt pending until the expired flag is cleared
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_pend_ff <= 1'b0;
		end else if (timeout && (mode_ff == wdt_pkg::MODE_IRQ || mode_ff == wdt_pkg::MODE_DUAL)) begin
			irq_pend_ff <= 1'b1;
		end else if (clr_expired) begin
			irq_pend_ff <= 1'b0;
		end
	end

	// Routed interrupt line, driven from a flop
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= irq_pend_ff && (route_ff == `WDT_ROUTE_LINE5);
		end
	end

	// Reset cause flag: set wins over write-one clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cause_ff <= 1'b0;
		end else if (fire_reset) begin
			cause_ff <= 1'b1;
		end else if (wr_en_in && addr_in == `WDT_ADDR_RESET_CAUSE && wr_data_in[`WDT_CAUSE_BIT]) begin
			cause_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Hard reset pulse
	// ----------------------------------------------------------------
	// Fixed-width pulse; this block is on power-on reset only
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rst_cnt_ff <= 6'h0;
			rst_out_ff <= 1'b0;
		end else if (fire_reset) begin
			rst_cnt_ff <= 6'(RST_PULSE - 1);
			rst_out_ff <= 1'b1;
		end else if (rst_cnt_ff != 6'h0) begin
			rst_cnt_ff <= rst_cnt_ff - 6'h1;
		end else begin
			rst_out_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_rd.expired_flag = expired_ff;
		ctrl_rd.timeout_behaviour_select = mode_ff;
		ctrl_rd.arm_retrigger_bit = armed;
		ctrl_rd.period_select = period_ff;
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !rd_en_in) begin
			rd_data_ff <= 8'h0;
		end else begin
			unique case (addr_in)
				`WDT_ADDR_CONTROL: rd_data_ff <= ctrl_rd;
				`WDT_ADDR_IRQ_ROUTING: rd_data_ff <= {6'h0, route_ff};
				`WDT_ADDR_RESET_CAUSE: rd_data_ff <= {7'h0, cause_ff};
				default: rd_data_ff <= 8'h0; // Unmapped reads zero
			endcase
		end
	end

	assign rd_data_out = rd_data_ff;
	assign irq_line5_out = irq_ff;
	assign hard_reset_out = rst_out_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_dual_first;
		timeout && !arm_req && mode_ff == wdt_pkg::MODE_DUAL && state_ff == wdt_pkg::ST_COUNTING;
	endsequence
	sequence s_dual_second;
		timeout && mode_ff == wdt_pkg::MODE_DUAL && state_ff == wdt_pkg::ST_GRACE;
	endsequence

	property p_disarmed_quiet;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!armed |-> !expired_ff && !irq_pend_ff && !hard_reset_out;
	endproperty
	a_disarmed_quiet: assert property (p_disarmed_quiet) else $error("activity while disarmed");
	property p_mode_locked;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		armed |=> armed && mode_ff == $past(mode_ff);
	endproperty
	a_mode_locked: assert property (p_mode_locked) else $error("armed mode changed");
	property p_retrigger_load;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		arm_req |=> cnt_ff == $past(load_val) && tick_cnt_ff == 23'h0;
	endproperty
	a_retrigger_load: assert property (p_retrigger_load) else $error("retrigger did not reload");
	property p_arm_readback;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_ctrl && armed |=> rd_data_out[`WDT_ARM_BIT];
	endproperty
	a_arm_readback: assert property (p_arm_readback) else $error("arm bit read zero");
	property p_timeout_flag;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		timeout |=> expired_ff;
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) else $error("expired flag not set");
	property p_flag_clear;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		clr_expired && !timeout |=> !expired_ff ##1 (!expired_ff || $past(timeout));
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("expired flag not cleared");
	property p_reset_mode;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		timeout && mode_ff == wdt_pkg::MODE_RESET |=> hard_reset_out [*8] and cause_ff;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("no hard reset in reset mode");
	property p_irq_mode;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		timeout && mode_ff == wdt_pkg::MODE_IRQ && route_ff == `WDT_ROUTE_LINE5 && !clr_expired
			|=> !hard_reset_out ##1 irq_line5_out;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("interrupt mode misbehaved");
	property p_dual_first;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		s_dual_first |=> state_ff == wdt_pkg::ST_GRACE && irq_pend_ff && cnt_ff == $past(period_val);
	endproperty
	a_dual_first: assert property (p_dual_first) else $error("dual first stage wrong");
	property p_dual_second;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		s_dual_second |=> hard_reset_out && cause_ff;
	endproperty
	a_dual_second: assert property (p_dual_second) else $error("dual second stage no reset");
	property p_irq_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		irq_pend_ff && !clr_expired |=> irq_pend_ff;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
endmodule // board_watchdog_timer

// [wdt_regs.svh]
// Register map, field positions and timing counts of the board watchdog
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define WDT_ADDR_RESET_CAUSE 10'h285
`define WDT_ADDR_IRQ_ROUTING 10'h286
`define WDT_ADDR_CONTROL 10'h28c
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDT_EXPIRED_BIT 7
`define WDT_MODE_MSB 6
`define WDT_MODE_LSB 5
`define WDT_ARM_BIT 4
`define WDT_PERIOD_MSB 3
`define WDT_PERIOD_LSB 0
`define WDT_ROUTE_MSB 1
`define WDT_ROUTE_LSB 0
`define WDT_CAUSE_BIT 0
// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define WDT_PERIOD_RST 4'h0
`define WDT_ROUTE_RST 2'h0
`define WDT_ROUTE_LINE5 2'h1
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDT_CLK_NS 25
`define WDT_TICK_NS 125000000
`define WDT_TICK_CYC ((`WDT_TICK_NS) / (`WDT_CLK_NS))
`define WDT_RST_PULSE_NS 1000
`define WDT_RST_PULSE_CYC (((`WDT_RST_PULSE_NS) + (`WDT_CLK_NS) - 1) / (`WDT_CLK_NS))
`endif

// [wdt_pkg.sv]
// Types shared by the board watchdog
package wdt_pkg;
	// Timeout behaviour select encodings
	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_RESET,
		MODE_IRQ,
		MODE_DUAL
	} mode_e;
	// Watchdog sequencing states
	typedef enum logic [1:0] {
		ST_DISARMED,
		ST_COUNTING,
		ST_GRACE,
		ST_EXPIRED
	} wdt_state_e;
	// Control register image
	typedef struct packed {
		logic expired_flag;
		mode_e timeout_behaviour_select;
		logic arm_retrigger_bit;
		logic [3:0] period_select;
	} ctrl_s;
endpackage

// [board_watchdog_timer_tb.sv]
// Self-checking testbench of the board watchdog timer
`timescale 1ns/1ps
`include "wdt_regs.svh"

module board_watchdog_timer_tb;
	// ------------------------------------------------
	// Signals and counters
	// ------------------------------------------------
	localparam int unsigned TICK = 4; // Short tick keeps the run brief
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [9:0] addr_in = 10'h000;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic [7:0] rd_data_out;
	logic irq_line5_out;
	logic hard_reset_out;
	int err_total = 0; // Mismatches seen
	int comparisons = 0; // Compares made

	board_watchdog_timer #(.TICK_CYCLES(TICK)) i_board_watchdog_timer (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out),
		.irq_line5_out(irq_line5_out),
		.hard_reset_out(hard_reset_out)
	);

	// 40 MHz clock
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	// Verdict and end of run
	task automatic give_verdict();
		$display("Compares %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Byte compare, four-state exact
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Power-on reset held for 12 cycles
	task automatic por();
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		repeat (12) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
	endtask

	// One-cycle write; returns just after the sampling edge
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_sys_in);
		wr_en_in <= 1'b0;
	endtask

	// One-cycle read, data judged in the following cycle
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_en_in <= 1'b0;
		@(negedge clk_sys_in);
		chk(rd_data_out, exp);
	endtask

	// Bounded wait for an output to rise; n counts half-way samples
	task automatic wait_for(input bit use_irq, input int lim, output int n);
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
			if (n > lim) begin
				err_total++;
				$display("FAIL at %0t: got %h expected %h", $time, 8'h00, 8'h01);
				give_verdict();
			end
		end while ((use_irq ? irq_line5_out : hard_reset_out) !== 1'b1);
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	// Idle state after power-on, unmapped place reads zero
	task automatic t_power_on();
		por();
		rd(`WDT_ADDR_CONTROL, 8'h00);
		rd(`WDT_ADDR_IRQ_ROUTING, 8'h00);
		rd(`WDT_ADDR_RESET_CAUSE, 8'h00);
		wr(10'h28d, 8'hff);
		rd(10'h28d, 8'h00);
		repeat (40) @(negedge clk_sys_in);
		chk({6'h00, irq_line5_out, hard_reset_out}, 8'h00);
		rd(`WDT_ADDR_CONTROL, 8'h00);
	endtask

	// Timer mode: exact expiry for period codes 0 to 6, lock, clear
	task automatic t_timer_periods();
		int t;
		wr(`WDT_ADDR_CONTROL, 8'h00);
		for (int n = 0; n < 7; n++) begin
			t = (1 << n) * TICK;
			wr(`WDT_ADDR_CONTROL, 8'h90 | n[7:0]);
			repeat (t - 2) @(posedge clk_sys_in);
			rd(`WDT_ADDR_CONTROL, 8'h10 | n[7:0]);
			rd(`WDT_ADDR_CONTROL, 8'h90 | n[7:0]);
			chk({6'h00, irq_line5_out, hard_reset_out}, 8'h00);
		end
		wr(`WDT_ADDR_CONTROL, 8'h60);
		rd(`WDT_ADDR_CONTROL, 8'h90);
		wr(`WDT_ADDR_CONTROL, 8'h80);
		rd(`WDT_ADDR_CONTROL, 8'h10);
		// Retrigger in mid-count postpones expiry
		wr(`WDT_ADDR_CONTROL, 8'h11);
		repeat (4) @(posedge clk_sys_in);
		wr(`WDT_ADDR_CONTROL, 8'h11);
		repeat (5) @(posedge clk_sys_in);
		rd(`WDT_ADDR_CONTROL, 8'h11);
		rd(`WDT_ADDR_CONTROL, 8'h91);
	endtask

	// Reset mode: pulse, cause flag, flag kept
	task automatic t_reset_mode();
		int n;
		int w;
		por();
		wr(`WDT_ADDR_CONTROL, 8'h20);
		wr(`WDT_ADDR_CONTROL, 8'h30);
		wait_for(1'b0, 20, n);
		w = 0;
		while (hard_reset_out === 1'b1 && w < 100) begin
			w++;
			@(negedge clk_sys_in);
		end
		chk(w[7:0], 8'h28);
		chk({7'h00, irq_line5_out}, 8'h00);
		rd(`WDT_ADDR_CONTROL, 8'hb0);
		rd(`WDT_ADDR_RESET_CAUSE, 8'h01);
		wr(`WDT_ADDR_RESET_CAUSE, 8'h00);
		rd(`WDT_ADDR_RESET_CAUSE, 8'h01);
		wr(`WDT_ADDR_RESET_CAUSE, 8'h01);
		rd(`WDT_ADDR_RESET_CAUSE, 8'h00);
	endtask

	// Interrupt mode: routing gate, held until flag cleared
	task automatic t_irq_mode();
		int n;
		por();
		wr(`WDT_ADDR_IRQ_ROUTING, 8'hff);
		rd(`WDT_ADDR_IRQ_ROUTING, 8'h03);
		wr(`WDT_ADDR_IRQ_ROUTING, 8'h01);
		wr(`WDT_ADDR_CONTROL, 8'h40);
		wr(`WDT_ADDR_CONTROL, 8'h50);
		wait_for(1'b1, 20, n);
		chk({7'h00, hard_reset_out}, 8'h00);
		rd(`WDT_ADDR_RESET_CAUSE, 8'h00);
		wr(`WDT_ADDR_IRQ_ROUTING, 8'h00);
		repeat (3) @(negedge clk_sys_in);
		chk({7'h00, irq_line5_out}, 8'h00);
		wr(`WDT_ADDR_IRQ_ROUTING, 8'h02);
		repeat (3) @(negedge clk_sys_in);
		chk({7'h00, irq_line5_out}, 8'h00);
		wr(`WDT_ADDR_IRQ_ROUTING, 8'h01);
		repeat (3) @(negedge clk_sys_in);
		chk({7'h00, irq_line5_out}, 8'h01);
		wr(`WDT_ADDR_CONTROL, 8'hc0);
		repeat (3) @(negedge clk_sys_in);
		chk({7'h00, irq_line5_out}, 8'h00);
		rd(`WDT_ADDR_CONTROL, 8'h50);
	endtask

	// Dual stage: retrigger after first stage, then unbroken second stage
	task automatic t_dual_mode();
		int n;
		por();
		wr(`WDT_ADDR_IRQ_ROUTING, 8'h01);
		wr(`WDT_ADDR_CONTROL, 8'h62);
		wr(`WDT_ADDR_CONTROL, 8'h72);
		wait_for(1'b1, 40, n);
		chk({7'h00, hard_reset_out}, 8'h00);
		wr(`WDT_ADDR_CONTROL, 8'h72);
		wait_for(1'b0, 60, n);
		chk(8'((n >= 32) && (n <= 36)), 8'h01);
		rd(`WDT_ADDR_CONTROL, 8'hf2);
		rd(`WDT_ADDR_RESET_CAUSE, 8'h01);
	endtask

	// ------------------------------------------------
	// Main sequence and overall time limit
	// ------------------------------------------------
	initial begin
		t_power_on();
		t_timer_periods();
		t_reset_mode();
		t_irq_mode();
		t_dual_mode();
		give_verdict();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		err_total++;
		give_verdict();
	end
endmodule // board_watchdog_timer_tb
